// ===== src/eic_top.sv
// enclave init checker sequencer with axi4-lite register slave
`timescale 1ns/100ps
module eic_top
	import eic_pkg::*;
(
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address and data
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// axi4-lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// axi4-lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// outcome flags
	output logic             zero_flag,
	output logic             arith_flags_clear,
	output logic             page_initialized
);
	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		st_idle, st_align, st_copy, st_header, st_window, st_page,
		st_measure, st_attr, st_token, st_derive, st_mac, st_tokchk,
		st_commit, st_done
	} eic_state_t;

	eic_state_t           state;
	logic [31:0]          rec_addr;
	logic [31:0]          page_addr;
	logic [31:0]          tok_addr;
	logic [CK_WIDTH-1:0]  checks;
	logic [31:0]          upd_count;
	logic [31:0]          result;
	logic                 gp_fault;
	logic                 pg_fault;
	logic [31:0]          fault_addr;
	logic                 busy;
	logic                 done;
	logic [11:0]          copy_bytes;
	logic [11:0]          pad_bytes;
	logic [11:0]          mac_bytes;
	logic [41:0]          hash_len;
	logic [4:0]           commit_bits;
	logic [15:0]          key_pad_head;
	logic                 start_req;

	// ---------------------------------------------------------------
	// axi4-lite write channel: address and data taken in either order
	// ---------------------------------------------------------------
	logic        aw_held;
	logic        w_held;
	logic [7:0]  aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	wire         wr_fire = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr > REG_UPDCNT) ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// byte-lane merge for writable words
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// register writes; operands are frozen while busy
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rec_addr  <= 32'h0000_0000;
			page_addr <= 32'h0000_0000;
			tok_addr  <= 32'h0000_0000;
			checks    <= '0;
			upd_count <= 32'h0000_0000;
			start_req <= 1'b0;
		end else begin
			start_req <= 1'b0;
			if (wr_fire && !busy) begin
				if (aw_addr == REG_CTRL) begin
					start_req <= w_strb[0] & w_data[0];
				end else if (aw_addr == REG_RECADDR) begin
					rec_addr <= merge(rec_addr, w_data, w_strb);
				end else if (aw_addr == REG_PGADDR) begin
					page_addr <= merge(page_addr, w_data, w_strb);
				end else if (aw_addr == REG_TOKADDR) begin
					tok_addr <= merge(tok_addr, w_data, w_strb);
				end else if (aw_addr == REG_CHECKS) begin
					checks <= CK_WIDTH'(merge(32'(checks), w_data, w_strb));
				end else if (aw_addr == REG_UPDCNT) begin
					upd_count <= merge(upd_count, w_data, w_strb);
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// axi4-lite read channel
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OKAY;
				if (s_axi_araddr == REG_CTRL) begin
					s_axi_rdata <= 32'h0000_0000;
				end else if (s_axi_araddr == REG_STATUS) begin
					s_axi_rdata <= {26'h0, page_initialized, pg_fault, gp_fault,
						zero_flag, done, busy};
				end else if (s_axi_araddr == REG_RESULT) begin
					s_axi_rdata <= result;
				end else if (s_axi_araddr == REG_RECADDR) begin
					s_axi_rdata <= rec_addr;
				end else if (s_axi_araddr == REG_PGADDR) begin
					s_axi_rdata <= page_addr;
				end else if (s_axi_araddr == REG_TOKADDR) begin
					s_axi_rdata <= tok_addr;
				end else if (s_axi_araddr == REG_CHECKS) begin
					s_axi_rdata <= 32'(checks);
				end else if (s_axi_araddr == REG_UPDCNT) begin
					s_axi_rdata <= upd_count;
				end else if (s_axi_araddr == REG_LENLO) begin
					s_axi_rdata <= hash_len[31:0];
				end else if (s_axi_araddr == REG_CPYCNT) begin
					s_axi_rdata <= {4'h0, mac_bytes, 4'h0, copy_bytes};
				end else if (s_axi_araddr == REG_COMMIT) begin
					s_axi_rdata <= {fault_addr[31:PAGE_ALIGN_BITS], 7'h00, commit_bits};
				end else if (s_axi_araddr == REG_PADLEN) begin
					s_axi_rdata <= {key_pad_head, 4'h0, pad_bytes[11:0]};
				end else begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// sequencer: checks in a fixed order across states, first failure exits
	// ---------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state             <= st_idle;
			busy              <= 1'b0;
			done              <= 1'b0;
			result            <= 32'h0000_0000;
			zero_flag         <= 1'b0;
			arith_flags_clear <= 1'b0;
			gp_fault          <= 1'b0;
			pg_fault          <= 1'b0;
			fault_addr        <= 32'h0000_0000;
			copy_bytes        <= 12'h000;
			pad_bytes         <= 12'h000;
			mac_bytes         <= 12'h000;
			hash_len          <= '0;
			commit_bits       <= 5'h00;
			key_pad_head      <= 16'h0000;
			page_initialized  <= 1'b0;
		end else begin
			case (state)
			st_idle: begin
				if (start_req) begin
					state       <= st_align;
					busy        <= 1'b1;
					done        <= 1'b0;
					gp_fault    <= 1'b0;
					pg_fault    <= 1'b0;
					copy_bytes  <= 12'h000;
					commit_bits <= 5'h00;
					// stale padding and mac lengths would hide a skipped step
					pad_bytes    <= 12'h000;
					mac_bytes    <= 12'h000;
					key_pad_head <= 16'h0000;
				end
			end
			st_align: begin
				// alignment before any access to memory
				if (rec_addr[PAGE_ALIGN_BITS-1:0] != '0 ||
					page_addr[PAGE_ALIGN_BITS-1:0] != '0 ||
					tok_addr[TOKEN_ALIGN_BITS-1:0] != '0) begin
					gp_fault <= 1'b1;
					state    <= st_done;
				end else if (!checks[CK_IN_CACHE]) begin
					pg_fault   <= 1'b1;
					fault_addr <= page_addr;
					state      <= st_done;
				end else begin
					state <= st_copy;
				end
			end
			st_copy: begin
				// record and token copied a word per cycle before any content check
				copy_bytes <= copy_bytes + COPY_STEP;
				if (copy_bytes + COPY_STEP >= RECORD_BYTES + TOKEN_BYTES) begin
					state <= st_header;
				end
			end
			st_header: begin
				if (checks[CK_HDR_BAD]) begin
					result <= err_bad_record;
					state  <= st_done;
				end else begin
					state <= st_window;
				end
			end
			st_window: begin
				// interrupt polled ahead of the signature outcome
				if (checks[CK_IRQ]) begin
					result <= err_pending_event;
					state  <= st_done;
				end else if (!checks[CK_SIG_OK]) begin
					result <= err_signature_mismatch;
					state  <= st_done;
				end else begin
					pad_bytes <= PAD_SAVE_BYTES;
					state     <= st_page;
				end
			end
			st_page: begin
				if (checks[CK_CONC_PAGE]) begin
					gp_fault <= 1'b1;
					state    <= st_done;
				end else if (!checks[CK_MAP_VALID] || !checks[CK_TYPE_CTRL]) begin
					pg_fault   <= 1'b1;
					fault_addr <= page_addr;
					state      <= st_done;
				end else if (checks[CK_CONC_MEAS]) begin
					gp_fault <= 1'b1;
					state    <= st_done;
				end else begin
					hash_len <= 42'(upd_count) << LEN_SHIFT;
					state    <= st_measure;
				end
			end
			st_measure: begin
				if (!checks[CK_MEAS_EQ]) begin
					result <= err_measurement_mismatch;
					state  <= st_done;
				end else if (checks[CK_CTRL_ATTR] && !checks[CK_SIGNER_EQ]) begin
					result <= err_attribute_violation;
					state  <= st_done;
				end else begin
					state <= st_attr;
				end
			end
			st_attr: begin
				if (!checks[CK_ATTR_EQ] || !checks[CK_MISC_EQ]) begin
					result <= err_attribute_violation;
					state  <= st_done;
				end else begin
					state <= st_token;
				end
			end
			st_token: begin
				if (!checks[CK_TOK_VALID]) begin
					// no token: signer must match, then straight to commit
					if (!checks[CK_SIGNER_EQ]) begin
						result <= err_bad_token;
						state  <= st_done;
					end else begin
						state <= st_commit;
					end
				end else if (checks[CK_DBG_BAD] || checks[CK_TOK_RSVD]) begin
					result <= err_bad_token;
					state  <= st_done;
				end else if (checks[CK_VER_NEW]) begin
					result <= err_version_too_new;
					state  <= st_done;
				end else begin
					state <= st_derive;
				end
			end
			st_derive: begin
				// dependency padding head; the ff bytes follow it in the key buffer.
				// saved padding length is kept apart: commit still needs it
				key_pad_head <= KEY_PAD_HEAD;
				state        <= st_mac;
			end
			st_mac: begin
				mac_bytes <= MAC_SPAN_BYTES;
				if (!checks[CK_MAC_EQ]) begin
					result <= err_bad_token;
					state  <= st_done;
				end else begin
					state <= st_tokchk;
				end
			end
			st_tokchk: begin
				if (!checks[CK_TOKMEAS_EQ]) begin
					result <= err_measurement_mismatch;
					state  <= st_done;
				end else if (!checks[CK_TOKATTR_EQ]) begin
					result <= err_token_attribute_mismatch;
					state  <= st_done;
				end else begin
					state <= st_commit;
				end
			end
			st_commit: begin
				// fields and the initialized mark written in the same cycle
				commit_bits      <= COMMIT_ALL;
				page_initialized <= 1'b1;
				result           <= err_none;
				state            <= st_done;
			end
			st_done: begin
				// zero flag set on failure or fault; page untouched then
				zero_flag         <= (state == st_done) && (commit_bits != COMMIT_ALL);
				arith_flags_clear <= 1'b1;
				busy              <= 1'b0;
				done              <= 1'b1;
				state             <= st_idle;
			end
			default: state <= st_idle;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	a_align_fault: assert property (@(posedge aclk) disable iff (!aresetn)
		state == st_align && rec_addr[PAGE_ALIGN_BITS-1:0] != '0 |=> gp_fault)
		else $error("misaligned record did not fault");
	a_commit_init: assert property (@(posedge aclk) disable iff (!aresetn)
		state == st_commit |=> page_initialized && result == 32'(err_none))
		else $error("commit did not mark page");
	a_fail_zf: assert property (@(posedge aclk) disable iff (!aresetn)
		state == st_header && checks[CK_HDR_BAD] |=> ##1 zero_flag && done)
		else $error("failure did not set zero flag");
	a_irq_first: assert property (@(posedge aclk) disable iff (!aresetn)
		state == st_window && checks[CK_IRQ] |=> result == 32'(err_pending_event))
		else $error("pending event not reported");
	a_copy_first: assert property (@(posedge aclk) disable iff (!aresetn)
		state == st_header |-> copy_bytes >= RECORD_BYTES + TOKEN_BYTES)
		else $error("check before copy done");
	a_no_touch: assert property (@(posedge aclk) disable iff (!aresetn)
		state == st_done && $past(state) != st_commit |-> commit_bits == 5'h00)
		else $error("page touched on failure");
	a_version: assert property (@(posedge aclk) disable iff (!aresetn)
		state == st_token && checks[CK_TOK_VALID] && !checks[CK_DBG_BAD] && !checks[CK_TOK_RSVD]
		&& checks[CK_VER_NEW] |=> result == 32'(err_version_too_new))
		else $error("version check missed");
	a_len: assert property (@(posedge aclk) disable iff (!aresetn)
		state == st_measure && $past(state) == st_page |-> hash_len == 42'(upd_count) << LEN_SHIFT)
		else $error("hash length wrong");
	c_success: cover property (@(posedge aclk) state == st_commit);
	c_gp: cover property (@(posedge aclk) gp_fault && done);
	c_notoken: cover property (@(posedge aclk) state == st_token && !checks[CK_TOK_VALID]);
endmodule

// ===== src/eic_pkg.sv
// shared constants and types for the enclave init checker
package eic_pkg;
	// ---------------------------------------------------------------
	// register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_CTRL    = 8'h00; // w: bit0 start
	localparam logic [7:0] REG_STATUS  = 8'h04; // r: busy, done, zf, faults
	localparam logic [7:0] REG_RESULT  = 8'h08; // r: error code
	localparam logic [7:0] REG_RECADDR = 8'h0c; // record address low
	localparam logic [7:0] REG_PGADDR  = 8'h10; // control page address low
	localparam logic [7:0] REG_TOKADDR = 8'h14; // token address low
	localparam logic [7:0] REG_CHECKS  = 8'h18; // check outcome inputs
	localparam logic [7:0] REG_UPDCNT  = 8'h1c; // measurement update count
	localparam logic [7:0] REG_LENLO   = 8'h20; // r: hash length low word
	localparam logic [7:0] REG_CPYCNT  = 8'h24; // r: bytes copied
	localparam logic [7:0] REG_COMMIT  = 8'h28; // r: commit step bits
	localparam logic [7:0] REG_PADLEN  = 8'h2c; // r: saved padding length / key pad head
	// ---------------------------------------------------------------
	// check input bit positions in REG_CHECKS (1 = condition true)
	// ---------------------------------------------------------------
	localparam int CK_HDR_BAD    = 0;  // header/vendor/exponent/reserved bad
	localparam int CK_IRQ        = 1;  // interrupt pending in event window
	localparam int CK_SIG_OK     = 2;  // signature verified
	localparam int CK_CONC_PAGE  = 3;  // other op modifying control page
	localparam int CK_MAP_VALID  = 4;  // map entry valid
	localparam int CK_TYPE_CTRL  = 5;  // page type is control page type
	localparam int CK_CONC_MEAS  = 6;  // other op modifying measurement/init
	localparam int CK_IN_CACHE   = 7;  // page resolves in protected cache
	localparam int CK_MEAS_EQ    = 8;  // record hash equals measurement
	localparam int CK_CTRL_ATTR  = 9;  // controlled attribute set
	localparam int CK_SIGNER_EQ  = 10; // signer hash equals launch key hash
	localparam int CK_ATTR_EQ    = 11; // masked attributes equal
	localparam int CK_MISC_EQ    = 12; // masked misc select equal
	localparam int CK_TOK_VALID  = 13; // token valid bit 0
	localparam int CK_DBG_BAD    = 14; // launcher debug set, enclave debug clear
	localparam int CK_TOK_RSVD   = 15; // token reserved space nonzero
	localparam int CK_VER_NEW    = 16; // token version above current
	localparam int CK_MAC_EQ     = 17; // computed cmac equals token mac
	localparam int CK_TOKMEAS_EQ = 18; // token measurement and signer match
	localparam int CK_TOKATTR_EQ = 19; // token attributes equal page
	localparam int CK_WIDTH      = 20;
	// ---------------------------------------------------------------
	// sizes and alignment
	// ---------------------------------------------------------------
	localparam int          PAGE_ALIGN_BITS  = 12;   // 4KByte
	localparam int          TOKEN_ALIGN_BITS = 9;    // 512Byte
	localparam logic [11:0] RECORD_BYTES     = 12'h710; // 1808 bytes
	localparam logic [11:0] TOKEN_BYTES      = 12'h130; // 304 bytes
	localparam logic [11:0] COPY_STEP        = 12'h004; // one word per cycle
	localparam logic [11:0] PAD_SAVE_BYTES   = 12'h160; // 352 bytes
	localparam logic [11:0] MAC_SPAN_BYTES   = 12'h0c0; // 192 bytes
	localparam logic [15:0] KEY_PAD_HEAD     = 16'h0100;
	localparam logic [11:0] KEY_PAD_FF_BYTES = 12'h14a; // 330 bytes
	localparam int          LEN_SHIFT        = 9;       // times 512
	localparam logic [4:0]  COMMIT_ALL       = 5'h1f;
	// ---------------------------------------------------------------
	// result codes (shared error table)
	// ---------------------------------------------------------------
	typedef enum logic [31:0] {
		err_none                     = 32'h0000_0000,
		err_bad_record               = 32'h0000_0001,
		err_attribute_violation      = 32'h0000_0002,
		err_measurement_mismatch     = 32'h0000_0003,
		err_signature_mismatch       = 32'h0000_0004,
		err_bad_token                = 32'h0000_0005,
		err_version_too_new          = 32'h0000_0006,
		err_pending_event            = 32'h0000_0007,
		err_token_attribute_mismatch = 32'h0000_0008
	} eic_err_t;
	// permitted vendor code: value arbitrary
	localparam logic [31:0] VENDOR_CODE = 32'h0000_1234;
	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ===== dv/eic_axi_master.sv
// axi4-lite host model that issues the init requests
`timescale 1ns/100ps
module eic_axi_master (
	// clock
	input  wire logic        aclk,
	// write address and data
	output logic [7:0]       s_axi_awaddr,
	output logic             s_axi_awvalid,
	input  wire logic        s_axi_awready,
	output logic [31:0]      s_axi_wdata,
	output logic [3:0]       s_axi_wstrb,
	output logic             s_axi_wvalid,
	input  wire logic        s_axi_wready,
	// write response
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	output logic             s_axi_bready,
	// read
	output logic [7:0]       s_axi_araddr,
	output logic             s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	output logic             s_axi_rready
);
	// -------------------------------------------------------------
	// idle values
	// -------------------------------------------------------------
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
		s_axi_rready = 1'b0;
	end
	// address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	// rready stays up until the answer is sampled
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		forever begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
endmodule

// ===== dv/eic_top_bench.sv
// self-checking bench for the enclave init checker
`timescale 1ns/100ps
module eic_top_bench
	import eic_pkg::*;
();
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic zero_flag, arith_flags_clear, page_initialized;
	logic init_m = 1'b0;
	int err_total = 0;
	int samples_checked = 0;
	int res_m = 0;
	localparam logic [31:0] GOOD = 32'h000e_3db4; // every check passes, token valid
	eic_top dut_u (.*);
	eic_axi_master host_u (.*);
	initial forever #12.5 aclk = ~aclk;
	// -------------------------------------------------------------
	// reference model: -1 protection fault, -2 page fault, else code
	// -------------------------------------------------------------
	function automatic int mdl(logic [31:0] r, p, t, c);
		if (r[11:0] != 0 || p[11:0] != 0 || t[8:0] != 0) return -1;
		if (!c[7]) return -2;
		if (c[0]) return 1;
		if (c[1]) return 7;
		if (!c[2]) return 4;
		if (c[3]) return -1;
		if (!c[4] || !c[5]) return -2;
		if (c[6]) return -1;
		if (!c[8]) return 3;
		if ((c[9] && !c[10]) || !c[11] || !c[12]) return 2;
		if (!c[13]) return c[10] ? 0 : 5;
		if (c[14] || c[15] || !c[17]) return c[16] && !c[14] && !c[15] ? 6 : 5;
		if (c[16]) return 6;
		if (!c[18]) return 3;
		return c[19] ? 0 : 8;
	endfunction
	task automatic cmp(logic [31:0] got, logic [31:0] exp, string what);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// one full request: operands, outcome inputs, start, poll, compare
	task automatic run(logic [31:0] r, p, t, c, n);
		int m;
		int k;
		logic [31:0] d;
		logic [1:0] rs;
		m = mdl(r, p, t, c);
		host_u.wr(REG_RECADDR, r, rs);
		host_u.wr(REG_PGADDR, p, rs);
		host_u.wr(REG_TOKADDR, t, rs);
		host_u.wr(REG_CHECKS, c, rs);
		host_u.wr(REG_UPDCNT, n, rs);
		host_u.wr(REG_CTRL, 32'h1, rs);
		repeat (2) @(posedge aclk); // start pulse lands in the same cycle as the response
		for (k = 0; k < 2000; k++) begin
			host_u.rd(REG_STATUS, d, rs);
			if (d[1] === 1'b1 && d[0] === 1'b0) break;
		end
		if (m == 0) init_m = 1'b1;
		if (m >= 0) res_m = m;
		cmp(d[5:0], {init_m, m == -2, m == -1, m != 0, 2'b10}, "status");
		host_u.rd(REG_RESULT, d, rs);
		cmp(d, res_m, "result");
		cmp(zero_flag, m != 0, "zero flag");
		cmp(arith_flags_clear, 1'b1, "arith flags");
		cmp(page_initialized, init_m, "initialized");
		if (r[11:0] == 0 && p[11:0] == 0 && t[8:0] == 0 && c[7]) begin
			host_u.rd(REG_CPYCNT, d, rs);
			cmp(d[11:0], RECORD_BYTES + TOKEN_BYTES, "copied bytes");
		end
		if (m == 0) begin
			host_u.rd(REG_LENLO, d, rs);
			cmp(d, n << LEN_SHIFT, "hash length");
			host_u.rd(REG_COMMIT, d, rs);
			cmp(d[4:0], COMMIT_ALL, "commit steps");
			host_u.rd(REG_PADLEN, d, rs);
			cmp(d[11:0], PAD_SAVE_BYTES, "saved padding");
			cmp(d[31:16], c[13] ? KEY_PAD_HEAD : 16'h0000, "key pad head");
			if (c[13]) begin
				host_u.rd(REG_CPYCNT, d, rs);
				cmp(d[27:16], MAC_SPAN_BYTES, "mac span");
			end
		end
		$display("run finished, expected outcome %0d", m);
	endtask
	function automatic logic [31:0] adr(logic [31:0] mask);
		return ($urandom & mask) | (($urandom_range(0, 3) == 0) ? 32'h10 : 32'h0);
	endfunction
	// -------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------
	initial begin
		logic [31:0] d, c, x;
		logic [1:0] rs;
		void'($urandom(32'hc0ff));
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		host_u.rd(8'h30, d, rs);
		cmp(rs, RESP_SLVERR, "unmapped read resp");
		cmp(d, 32'h0, "unmapped read data");
		host_u.wr(8'h20, 32'h5, rs);
		cmp(rs, RESP_SLVERR, "read-only write resp");
		run(32'h0000_1800, 32'h2000, 32'h3200, GOOD, 1);
		run(32'h0000_1000, 32'h2004, 32'h3200, GOOD, 1);
		run(32'h0000_1000, 32'h2000, 32'h3100, GOOD, 1);
		// each outcome input broken alone; signer pairs keep the run failing
		for (int i = 0; i < 20; i++) begin
			x = (i == 9 || i == 13) ? 32'h400 : ((i == 10) ? 32'h2000 : 32'h0);
			run(32'h1000, 32'h2000, 32'h3200, GOOD ^ (32'h1 << i) ^ x, 3);
		end
		repeat (12) begin
			c = $urandom & 32'h000f_ffff;
			d = adr(32'hffff_f000);
			x = adr(32'hffff_fe00);
			if (mdl(d, 32'h2000, x, c) == 0) c[0] = 1'b1;
			run(d, 32'h2000, x, c, $urandom & 32'h00ff_ffff);
		end
		run(32'h7000, 32'h8000, 32'h9000, GOOD ^ 32'h2000, 2);
		run(32'h4000, 32'h5000, 32'h6000, GOOD, 32'h0000_0105);
		end_of_test();
	end
	initial begin
		repeat (60000) @(posedge aclk);
		err_total++;
		$display("wrong value at %0t: watchdog expired", $time);
		end_of_test();
	end
endmodule
